// ===== verilog/cbp_ctrl.sv
// Function
// - power_down_n is asynchronous, active low, and controls entry and exit of power-down.
// - Outputs are parked before the PLL is switched off.
// - Power-down seen low on two complementary rising edges parks outputs next falling edge.
// - Power-down mode bit 0: true output driven high at 2x, complementary tri-stated.
// - Power-down mode bit 1: both pins of every pair tri-stated.
// - Locked stable clocks within 1 ms of power-up or power-down release.
// - Mode bit 1: outputs driven high within 300 ms after power-down release.
// - Clock-stop change accepted only after stable over two complementary rising edges.
// - Stoppable outputs halt after their next transition; free-running ones keep toggling.
// - Stop drive bit 0: stopped true output driven high at 6x, complement undriven.
// - Stop drive bit 1: both pins of stopped pairs undriven.
// - On stop release all stopped outputs restart together, glitch-free, within 2-6 periods.
// - Stop drive bit 1: stopped outputs driven high within 10 ns of release.
// - One bit per pair: 0 free-running, 1 obeys clock stop.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cbp_ctrl #(
   parameter int NUM_PAIRS   = cbp_pkg::NUM_PAIRS_DEF,
   parameter int LOCK_CYCLES = cbp_pkg::LOCK_CYCLES,
   parameter int HALF_PERIOD = cbp_pkg::HALF_PERIOD_CYCLES
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   input  wire logic                        power_down_n,
   input  wire logic                        clock_stop_n,
   input  wire logic [cbp_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [cbp_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [cbp_pkg::DATA_W-1:0]  reg_rdata,
   output logic      [NUM_PAIRS-1:0]        clk_out_pos,
   output logic      [NUM_PAIRS-1:0]        clk_out_pos_oe,
   output logic      [NUM_PAIRS-1:0]        clk_out_pos_full,
   output logic      [NUM_PAIRS-1:0]        clk_out_neg,
   output logic      [NUM_PAIRS-1:0]        clk_out_neg_oe,
   output logic                             pll_enable
);
   import cbp_pkg::*;

   localparam int LOCK_W    = $clog2(LOCK_CYCLES + 1);
   localparam int REL_MAX_C = 2 * HALF_PERIOD + 2;

   logic pd_s;
   logic stop_s;
   logic tick;
   logic running;
   logic pos_rise;
   logic neg_rise;

   cbp_sync #(.RST_VAL(1'b1)) u_pd_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (power_down_n),
      .sync_out (pd_s)
   );

   // stop pin into the clock domain
   cbp_sync #(.RST_VAL(1'b1)) u_stop_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (clock_stop_n),
      .sync_out (stop_s)
   );

   cbp_div #(.DIV(HALF_PERIOD)) u_div (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .en      (running),
      .tick    (tick)
   );

   // register file
   logic [DATA_W-1:0] cfg_q, cfg_d;
   logic [DATA_W-1:0] out_en_q, out_en_d;
   logic [DATA_W-1:0] stoppable_q, stoppable_d;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] status_v;

   // power and stop state
   cbp_pwr_e          state_q, state_d;
   logic [LOCK_W-1:0] lock_cnt_q, lock_cnt_d;
   logic              phase_q, phase_d;
   logic              pll_d;
   logic              pd_samp_q, pd_samp_d;
   logic              stop_samp_q, stop_samp_d;
   logic              stop_req_q, stop_req_d;
   logic [NUM_PAIRS-1:0] stopped_q, stopped_d;
   logic              rel_q, rel_d;

   logic [NUM_PAIRS-1:0] pos_d, pos_oe_d, full_d, neg_d, neg_oe_d;

   assign running  = (state_q == PWR_RUN) || (state_q == PWR_ARMED);
   // complementary output rises when the true output falls
   assign neg_rise = tick & phase_q;
   assign pos_rise = tick & ~phase_q;

   always_comb begin
      cfg_d       = cfg_q;
      out_en_d    = out_en_q;
      stoppable_d = stoppable_q;
      rdata_d     = '0;
      status_v    = '0;
      status_v[ST_DOWN_BIT] = (state_q == PWR_DOWN);
      status_v[ST_STOP_BIT] = stop_req_q;
      status_v[ST_RUN_BIT]  = running;
      status_v[ST_STOPPED_LSB +: NUM_PAIRS] = stopped_q;
      if (reg_wr) begin
         if (reg_addr == REG_CFG) begin
            cfg_d = reg_wdata;
         end else if (reg_addr == REG_OUT_EN) begin
            out_en_d = reg_wdata;
         end else if (reg_addr == REG_STOPPABLE) begin
            stoppable_d = reg_wdata;
         end
      end
      if (reg_rd) begin
         if (reg_addr == REG_CFG) begin
            rdata_d = cfg_q;
         end else if (reg_addr == REG_OUT_EN) begin
            rdata_d = out_en_q;
         end else if (reg_addr == REG_STOPPABLE) begin
            rdata_d = stoppable_q;
         end else if (reg_addr == REG_STATUS) begin
            rdata_d = status_v;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q       <= CFG_RST;
         out_en_q    <= OUT_EN_RST;
         stoppable_q <= STOPPABLE_RST;
         reg_rdata   <= '0;
      end else begin
         cfg_q       <= cfg_d;
         out_en_q    <= out_en_d;
         stoppable_q <= stoppable_d;
         reg_rdata   <= rdata_d;
      end
   end

   // power sequencing; reset starts in lock as after supply ramp
   always_comb begin
      state_d    = state_q;
      lock_cnt_d = lock_cnt_q;
      phase_d    = phase_q;
      pll_d      = pll_enable;
      pd_samp_d  = pd_samp_q;
      case (state_q)
         PWR_RUN: begin
            if (tick) begin
               phase_d = ~phase_q;
            end
            if (neg_rise) begin
               pd_samp_d = pd_s;
               if (!pd_s && !pd_samp_q) begin
                  state_d = PWR_ARMED;
               end
            end
         end
         PWR_ARMED: begin
            if (tick) begin
               phase_d = ~phase_q;
            end
            // park on the next falling complementary edge
            if (pos_rise) begin
               state_d = PWR_PARKED;
            end
         end
         PWR_PARKED: begin
            state_d = PWR_DOWN;
         end
         PWR_DOWN: begin
            // pll drops only once outputs sit parked
            pll_d = 1'b0;
            if (pd_s) begin
               state_d    = PWR_LOCK;
               pll_d      = 1'b1;
               lock_cnt_d = '0;
            end
         end
         PWR_LOCK: begin
            // lock wait bounded by the lock count
            if (!pd_s) begin
               state_d = PWR_DOWN;
               pll_d   = 1'b0;
            end else if (lock_cnt_q == LOCK_W'(LOCK_CYCLES - 1)) begin
               state_d   = PWR_RUN;
               phase_d   = 1'b0;
               pd_samp_d = 1'b1;
            end else begin
               lock_cnt_d = lock_cnt_q + 1'b1;
            end
         end
         default: begin
            state_d = PWR_LOCK;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= PWR_LOCK;
         lock_cnt_q <= '0;
         phase_q    <= 1'b0;
         pll_enable <= 1'b1;
         pd_samp_q  <= 1'b1;
      end else begin
         state_q    <= state_d;
         lock_cnt_q <= lock_cnt_d;
         phase_q    <= phase_d;
         pll_enable <= pll_d;
         pd_samp_q  <= pd_samp_d;
      end
   end

   // clock-stop handling; only meaningful while the pll runs
   always_comb begin
      stop_samp_d = stop_samp_q;
      stop_req_d  = stop_req_q;
      stopped_d   = stopped_q;
      rel_d       = rel_q;
      if (!running) begin
         stop_samp_d = 1'b1;
         stop_req_d  = 1'b0;
         stopped_d   = '0;
         rel_d       = 1'b0;
      end else begin
         // accept only a level held over two edges
         if (neg_rise) begin
            stop_samp_d = stop_s;
            if (stop_s == stop_samp_q) begin
               stop_req_d = ~stop_s;
               // drive high at once on release
               if (stop_req_q && stop_s) begin
                  rel_d = cfg_q[CFG_STOP_DRIVE_BIT] && (|stopped_q);
               end
            end
         end
         if (pos_rise) begin
            if (stop_req_q) begin
               // halt as the true output goes high
               stopped_d = stopped_q | stoppable_q[NUM_PAIRS-1:0];
            end else begin
               // all pairs restart on one edge
               stopped_d = '0;
               rel_d     = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_samp_q <= 1'b1;
         stop_req_q  <= 1'b0;
         stopped_q   <= '0;
         rel_q       <= 1'b0;
      end else begin
         stop_samp_q <= stop_samp_d;
         stop_req_q  <= stop_req_d;
         stopped_q   <= stopped_d;
         rel_q       <= rel_d;
      end
   end

   // pin drive per pair; full = 6x reference current, else 2x
   always_comb begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
         pos_d[i]    = 1'b1;
         full_d[i]   = 1'b0;
         neg_d[i]    = 1'b0;
         neg_oe_d[i] = 1'b0;
         if (!(running && out_en_q[i])) begin
            // park style from mode bit; lock drives high
            pos_oe_d[i] = !cfg_q[CFG_PD_MODE_BIT] || (state_q == PWR_LOCK);
         end else if (stopped_q[i]) begin
            full_d[i]   = 1'b1;
            pos_oe_d[i] = !cfg_q[CFG_STOP_DRIVE_BIT] || rel_q;
         end else begin
            pos_d[i]    = phase_q;
            pos_oe_d[i] = 1'b1;
            full_d[i]   = 1'b1;
            neg_d[i]    = ~phase_q;
            neg_oe_d[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_out_pos      <= '1;
         clk_out_pos_oe   <= '1;
         clk_out_pos_full <= '0;
         clk_out_neg      <= '0;
         clk_out_neg_oe   <= '0;
      end else begin
         clk_out_pos      <= pos_d;
         clk_out_pos_oe   <= pos_oe_d;
         clk_out_pos_full <= full_d;
         clk_out_neg      <= neg_d;
         clk_out_neg_oe   <= neg_oe_d;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_pd_seen;
      neg_rise && !pd_s && !pd_samp_q && state_q == PWR_RUN;
   endsequence
   sequence s_stop_release;
      $fell(stop_req_q) && cfg_q[CFG_STOP_DRIVE_BIT] && (|$past(stopped_q));
   endsequence

   logic [NUM_PAIRS-1:0] held_stop;
   logic [NUM_PAIRS-1:0] stopped_prev_q;

   // pins lag the stop mask by one cycle, so checks need last cycle's mask
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stopped_prev_q <= '0;
      end else begin
         stopped_prev_q <= stopped_q;
      end
   end

   assign held_stop = stopped_q & stopped_prev_q & out_en_q[NUM_PAIRS-1:0];

   a_pd_arm: assert property (s_pd_seen |=> state_q == PWR_ARMED)
      else $error("power-down not armed after two low samples");
   a_pd_park_edge: assert property (state_q == PWR_ARMED && pos_rise |=> state_q == PWR_PARKED ##1
      state_q == PWR_DOWN && clk_out_neg_oe == '0)
      else $error("outputs not parked on the falling complementary edge");
   a_park_before_pll: assert property ($fell(pll_enable) |-> clk_out_neg_oe == '0 && clk_out_pos == '1 &&
      $past(clk_out_neg_oe) == '0)
      else $error("pll shut off before outputs parked");
   a_pd_mode0: assert property (state_q == PWR_DOWN && $past(state_q) == PWR_DOWN &&
      !cfg_q[CFG_PD_MODE_BIT] && !$past(cfg_q[CFG_PD_MODE_BIT])
      |-> clk_out_pos == '1 && clk_out_pos_oe == '1 && clk_out_pos_full == '0 && clk_out_neg_oe == '0)
      else $error("mode 0 park drive wrong");
   a_pd_mode1: assert property (state_q == PWR_DOWN && $past(state_q) == PWR_DOWN &&
      cfg_q[CFG_PD_MODE_BIT] && $past(cfg_q[CFG_PD_MODE_BIT])
      |-> clk_out_pos_oe == '0 && clk_out_neg_oe == '0)
      else $error("mode 1 park not tri-stated");
   a_lock_exit: assert property (state_q == PWR_RUN && $past(state_q) == PWR_LOCK
      |-> $past(lock_cnt_q) == LOCK_W'(LOCK_CYCLES - 1))
      else $error("lock wait length wrong");
   a_lock_drive: assert property (state_q == PWR_LOCK && $past(state_q) == PWR_LOCK
      |-> clk_out_pos_oe == '1)
      else $error("outputs not driven high while locking");
   a_stop_qualify: assert property ($changed(stop_req_q) && $past(running) && running
      |-> $past(neg_rise) && $past(stop_s) == $past(stop_samp_q))
      else $error("clock stop accepted without two stable samples");
   a_stop_halt: assert property (pos_rise && stop_req_q && running |=>
      (stopped_q & $past(stoppable_q[NUM_PAIRS-1:0])) == $past(stoppable_q[NUM_PAIRS-1:0]) &&
      (stopped_q & ~$past(stoppable_q[NUM_PAIRS-1:0])) == ($past(stopped_q) & ~$past(stoppable_q[NUM_PAIRS-1:0])))
      else $error("stoppable pair not halted or free pair halted");
   a_stop_drive0: assert property (running && !cfg_q[CFG_STOP_DRIVE_BIT] && !$past(cfg_q[CFG_STOP_DRIVE_BIT])
      |-> (clk_out_pos & held_stop) == held_stop && (clk_out_pos_full & held_stop) == held_stop &&
      (clk_out_neg_oe & held_stop) == '0)
      else $error("stopped pair drive wrong in driven mode");
   a_stop_drive1: assert property (running && cfg_q[CFG_STOP_DRIVE_BIT] && $past(cfg_q[CFG_STOP_DRIVE_BIT]) &&
      !rel_q && !$past(rel_q) |-> ((clk_out_pos_oe | clk_out_neg_oe) & held_stop) == '0)
      else $error("stopped pair driven in tri-state mode");
   a_restart_all: assert property (running && $past(running) && $past(stopped_q) != '0 &&
      stopped_q != $past(stopped_q) |-> stopped_q == '0 || (stopped_q & $past(stopped_q)) == $past(stopped_q))
      else $error("stopped pairs did not restart together");
   a_restart_bound: assert property ($rose(rel_q) |-> ##[1:REL_MAX_C] !rel_q)
      else $error("restart after release too late");
   a_release_drive: assert property (s_stop_release |=>
      (clk_out_pos_oe & $past(stopped_q,2) & out_en_q[NUM_PAIRS-1:0]) == ($past(stopped_q,2) & out_en_q[NUM_PAIRS-1:0]))
      else $error("stopped outputs not driven high after release");
endmodule
`default_nettype wire

// ===== verilog/cbp_pkg.sv
`default_nettype none
package cbp_pkg;
   localparam int NUM_PAIRS_DEF = 4;
   localparam int ADDR_W        = 4;
   localparam int DATA_W        = 8;

   localparam logic [ADDR_W-1:0] REG_CFG       = 4'h0;
   localparam logic [ADDR_W-1:0] REG_OUT_EN    = 4'h1;
   localparam logic [ADDR_W-1:0] REG_STOPPABLE = 4'h2;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h3;

   localparam int CFG_PD_MODE_BIT    = 7;
   localparam int CFG_STOP_DRIVE_BIT = 6;
   localparam logic [DATA_W-1:0] CFG_RST       = 8'h00;
   localparam logic [DATA_W-1:0] OUT_EN_RST    = 8'h0F;
   localparam logic [DATA_W-1:0] STOPPABLE_RST = 8'h00;

   localparam int ST_DOWN_BIT    = 0;
   localparam int ST_STOP_BIT    = 1;
   localparam int ST_RUN_BIT     = 2;
   localparam int ST_STOPPED_LSB = 4;

   localparam int CLK_MHZ            = 250;
   localparam int LOCK_TIME_US       = 1000;
   localparam int LOCK_CYCLES        = LOCK_TIME_US * CLK_MHZ;
   localparam int STOP_DRIVE_NS      = 10;
   localparam int STOP_DRIVE_CYCLES  = STOP_DRIVE_NS * CLK_MHZ / 1000;
   localparam int HALF_PERIOD_CYCLES = 2;
   localparam int RESTART_MAX_PERIODS = 6;

   typedef enum logic [2:0] {
      PWR_RUN    = 3'b000,
      PWR_ARMED  = 3'b001,
      PWR_PARKED = 3'b010,
      PWR_DOWN   = 3'b011,
      PWR_LOCK   = 3'b100
   } cbp_pwr_e;
endpackage
`default_nettype wire

// ===== verilog/cbp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cbp_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      sync_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic out_d;

   always_comb begin
      out_d = sync_out;
      if (s2_q == s3_q) begin
         out_d = s3_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q     <= RST_VAL;
         s2_q     <= RST_VAL;
         s3_q     <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         s1_q     <= async_in;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         sync_out <= out_d;
      end
   end

   // a change passes only once two stages agree
   a_sync_agree: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $changed(sync_out) |-> $past(s2_q) == $past(s3_q))
      else $error("sync output changed while stages disagreed");
endmodule
`default_nettype wire

// ===== verilog/cbp_div.sv
`timescale 1ns/1ps
`default_nettype none
module cbp_div #(
   parameter int DIV = 2
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic en,
   output logic      tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          tick_d;

   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!en) begin
         cnt_d = '0;
      end else if (cnt_q == CW'(DIV - 1)) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule
`default_nettype wire

// ===== tb/cbp_pm_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbp_pm_model #(
   parameter int MIN_HOLD = 16
) (
   input  wire logic sys_clk,
   input  wire logic pd_req,
   input  wire logic stop_req,
   input  wire logic glitch_pd,
   input  wire logic glitch_stop,
   output var  logic power_down_n,
   output var  logic clock_stop_n
);
   int stop_hold;

   initial begin
      power_down_n = 1'b1;
      clock_stop_n = 1'b1;
      stop_hold    = 0;
   end

   always @(posedge sys_clk) begin
      // pins move off the block's clock edge, as a foreign domain would
      #1.3;
      if (stop_hold > 0) begin
         stop_hold = stop_hold - 1;
      end
      if (glitch_stop) begin
         clock_stop_n = stop_req;
      end else if (clock_stop_n === stop_req && stop_hold == 0) begin
         clock_stop_n = ~stop_req;
         stop_hold    = MIN_HOLD;
      end
      if (glitch_pd) begin
         power_down_n = pd_req;
      end else begin
         power_down_n = ~pd_req;
      end
   end
endmodule
`default_nettype wire

// ===== tb/clock_buffer_powerdown_stop_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clock_buffer_powerdown_stop_ctrl_bench;
   import cbp_pkg::*;
   localparam int LK = 20;
   logic              sys_clk;
   logic              rst_n;
   logic              power_down_n;
   logic              clock_stop_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic [DATA_W-1:0] rdv;
   logic              reg_wr;
   logic              reg_rd;
   logic              pll_enable;
   logic [3:0]        pos;
   logic [3:0]        pos_oe;
   logic [3:0]        full;
   logic [3:0]        neg;
   logic [3:0]        neg_oe;
   logic [3:0]        pos_pin;
   logic [3:0]        neg_pin;
   logic              pd_req;
   logic              stop_req;
   logic              glitch_pd;
   logic              glitch_stop;
   int                error_cnt;
   int                check_count;
   int                n;

   // undriven pins fall to the termination level
   assign pos_pin = pos & pos_oe;
   assign neg_pin = neg & neg_oe;

   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   cbp_ctrl #(.NUM_PAIRS(4), .LOCK_CYCLES(LK), .HALF_PERIOD(2)) u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .power_down_n(power_down_n), .clock_stop_n(clock_stop_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .clk_out_pos(pos), .clk_out_pos_oe(pos_oe), .clk_out_pos_full(full),
      .clk_out_neg(neg), .clk_out_neg_oe(neg_oe), .pll_enable(pll_enable));

   cbp_pm_model u_pm (
      .sys_clk(sys_clk), .pd_req(pd_req), .stop_req(stop_req), .glitch_pd(glitch_pd),
      .glitch_stop(glitch_stop), .power_down_n(power_down_n), .clock_stop_n(clock_stop_n));

   task automatic report_and_stop();
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input bit ok, input string msg);
      check_count++;
      if (!ok) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] d;
      rd(a, d);
      chk(d === e, $sformatf("read %0h got %0h", a, d));
   endtask

   function automatic bit cond(input int sel);
      case (sel)
         0: return neg_oe === 4'hA;
         1: return pos_oe === 4'hA;
         2: return pos === 4'hF && pos_oe === 4'hF && neg_oe === 4'h0;
         3: return pos_oe === 4'h0 && neg_oe === 4'h0;
         4: return pos[0] === 1'b0;
         5: return pos_oe === 4'hF;
         6: return pll_enable === 1'b0;
         7: return pos[0] === 1'b0 && pos[2] === 1'b0;
         default: return pos === 4'hF && pos_oe === 4'hF;
      endcase
   endfunction

   task automatic wait_for(input int sel, input int lim, output int cnt);
      cnt = 0;
      #1;
      while (!cond(sel) && cnt < lim) begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end
      chk(cnt < lim, $sformatf("wait %0d ran out", sel));
   endtask

   task automatic chk_run(input logic [3:0] exp);
      logic [3:0] prev;
      logic [3:0] seen;
      logic [3:0] bad;
      seen = 4'h0;
      bad  = 4'h0;
      #1;
      prev = pos_pin;
      repeat (8) begin
         @(posedge sys_clk);
         #1;
         seen = seen | (pos_pin ^ prev);
         bad  = bad | ((neg_pin ^ ~pos_pin) & exp);
         prev = pos_pin;
      end
      chk(seen === exp && bad === 4'h0, $sformatf("toggling pairs %0h", seen));
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pd_req = 1'b0;
      stop_req = 1'b0;
      glitch_pd = 1'b0;
      glitch_stop = 1'b0;
      error_cnt = 0;
      check_count = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      wait_for(4, LK + 20, n);
      chk(n >= LK && n <= LK + 10, "lock time");
      rd_chk(REG_CFG, CFG_RST);
      rd_chk(REG_OUT_EN, OUT_EN_RST);
      rd_chk(REG_STOPPABLE, STOPPABLE_RST);
      chk_run(4'hF);
      wr(REG_STATUS, 8'hFF);
      rd_chk(REG_STATUS, 8'h04);
      rd_chk(4'h9, 8'h00);
      wr(REG_CFG, 8'hC0);
      rd_chk(REG_CFG, 8'hC0);
      wr(REG_CFG, 8'h00);
      // stop with driven park, pairs 0 and 2 stoppable
      wr(REG_STOPPABLE, 8'h05);
      @(posedge sys_clk) stop_req <= 1'b1;
      wait_for(0, 40, n);
      chk(n >= 8, "stop taken too early");
      chk(pos_pin[0] === 1'b1 && pos_pin[2] === 1'b1 && neg_pin[0] === 1'b0 && neg_oe[2] === 1'b0,
          "stopped pair levels");
      chk(full === 4'hF, "stopped drive not full");
      chk_run(4'hA);
      rd(REG_STATUS, rdv);
      chk(rdv[7:4] === 4'h5 && rdv[1] === 1'b1, "stop status");
      @(posedge sys_clk) stop_req <= 1'b0;
      wait_for(7, 40, n);
      chk(n >= 8 && n <= 30, "restart latency");
      chk_run(4'hF);
      repeat (20) @(posedge sys_clk);
      // one-cycle stop pulse must be ignored
      @(posedge sys_clk) glitch_stop <= 1'b1;
      @(posedge sys_clk) glitch_stop <= 1'b0;
      repeat (12) @(posedge sys_clk);
      chk_run(4'hF);
      // stop with tri-stated park
      wr(REG_CFG, 8'h40);
      @(posedge sys_clk) stop_req <= 1'b1;
      wait_for(1, 40, n);
      chk(neg_oe[0] === 1'b0 && neg_oe[2] === 1'b0 && pos_pin[0] === 1'b0, "stop tri pins");
      chk_run(4'hA);
      @(posedge sys_clk) stop_req <= 1'b0;
      wait_for(5, 30, n);
      chk(pos[0] === 1'b1 && pos[2] === 1'b1, "restart not high first");
      repeat (12) @(posedge sys_clk);
      chk_run(4'hF);
      wr(REG_CFG, 8'h00);
      // power-down, driven park
      @(posedge sys_clk) pd_req <= 1'b1;
      wait_for(2, 40, n);
      chk(n >= 8 && full === 4'h0 && pll_enable === 1'b1, "park mode 0");
      wait_for(6, 3, n);
      rd(REG_STATUS, rdv);
      chk(rdv[0] === 1'b1, "not powered down");
      @(posedge sys_clk) pd_req <= 1'b0;
      wait_for(4, LK + 40, n);
      chk(n >= LK && pll_enable === 1'b1, "relock");
      // power-down, tri-stated park
      wr(REG_CFG, 8'h80);
      @(posedge sys_clk) pd_req <= 1'b1;
      wait_for(3, 40, n);
      repeat (4) @(posedge sys_clk);
      @(posedge sys_clk) pd_req <= 1'b0;
      wait_for(8, 12, n);
      wait_for(4, LK + 40, n);
      wr(REG_CFG, 8'h00);
      // one-cycle power-down pulse must be ignored
      @(posedge sys_clk) glitch_pd <= 1'b1;
      @(posedge sys_clk) glitch_pd <= 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      chk(pll_enable === 1'b1, "short power-down taken");
      chk_run(4'hF);
      // disabled pair parks like power-down
      wr(REG_OUT_EN, 8'h0E);
      repeat (12) @(posedge sys_clk);
      chk_run(4'hE);
      chk(pos_pin[0] === 1'b1 && neg_oe[0] === 1'b0, "disabled pair");
      report_and_stop();
   end
endmodule
`default_nettype wire
